// ### design/fsrg_top.sv
// Behaviour
// - Frame sync at sample rate, falling edge starts transfer
// - Each transfer interval lasts sixteen shift clocks
// - Sample period spans successive frame sync falls
// - Prescale eight means coarse; reset default
// - Coarse rate: clock over 16*M*N*8
// - Fine rate: clock over 16*M*N*P
// - ADC word out, host word to DAC
`timescale 1ns/10ps

module fsrg_top (
    input  wire logic                       CLOCK,
    input  wire logic                       RST,
    input  wire fsrg_pkg::fsrg_cfg_t        CFG,
    input  wire logic                       CFG_WR,
    input  wire logic [fsrg_pkg::WORD_W-1:0] ADC_WORD,
    input  wire logic                       SER_DIN,
    output logic                            FRAME_SYNC_N,
    output logic                            SHIFT_CLK,
    output logic                            SER_DOUT,
    output logic [fsrg_pkg::WORD_W-1:0]     DAC_WORD,
    output logic                            DAC_VALID,
    output logic                            FINE_MODE
);

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    fsrg_pkg::fsrg_cfg_t cfg_r;
    logic                restart;

    assign restart = CFG_WR;

    // Divider setting; reset lands in coarse mode
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            cfg_r.m <= fsrg_pkg::M_DEFAULT;
            cfg_r.n <= fsrg_pkg::N_DEFAULT;
            cfg_r.p <= fsrg_pkg::P_COARSE;
        end
        else if (CFG_WR)
        begin
            cfg_r <= CFG;
        end
    end

    // Mode flag follows the stored prescale value
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            FINE_MODE <= 1'b0;
        end
        else
        begin
            FINE_MODE <= (cfg_r.p != fsrg_pkg::P_COARSE);
        end
    end

    // ------------------------------------------------------------
    // Divider chain: P, then N, then M gives one shift tick
    // ------------------------------------------------------------
    logic tick_p;
    logic tick_n;
    logic tick_m;

    fsrg_div #(.W(fsrg_pkg::P_W)) u_div_p (
        .clk     (CLOCK),
        .rst     (RST),
        .restart (restart),
        .en      (1'b1),
        .div     (cfg_r.p),
        .tick    (tick_p)
    );

    fsrg_div #(.W(fsrg_pkg::N_W)) u_div_n (
        .clk     (CLOCK),
        .rst     (RST),
        .restart (restart),
        .en      (tick_p),
        .div     (cfg_r.n),
        .tick    (tick_n)
    );

    fsrg_div #(.W(fsrg_pkg::M_W)) u_div_m (
        .clk     (CLOCK),
        .rst     (RST),
        .restart (restart),
        .en      (tick_n),
        .div     (cfg_r.m),
        .tick    (tick_m)
    );

    // ------------------------------------------------------------
    // Serial input synchroniser
    // ------------------------------------------------------------
    logic [fsrg_pkg::SYNC_STAGES-1:0] din_q_r;
    logic                             din_s_r;

    // Three stages; value moves only when the last two agree
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            din_q_r <= '0;
            din_s_r <= 1'b0;
        end
        else
        begin
            din_q_r <= {din_q_r[fsrg_pkg::SYNC_STAGES-2:0], SER_DIN};
            if (din_q_r[1] == din_q_r[2])
            begin
                din_s_r <= din_q_r[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer and transmit shifter
    // ------------------------------------------------------------
    logic [fsrg_pkg::BIT_W-1:0]  bit_r;
    logic [fsrg_pkg::WORD_W-1:0] tx_r;
    logic                        first_r;
    logic                        frame_start;

    assign frame_start = tick_m && (bit_r == fsrg_pkg::BIT_LAST);

    // Idles at the last bit so the first tick opens a frame at once
    always_ff @(posedge CLOCK)
    begin
        if (RST || restart)
        begin
            bit_r        <= fsrg_pkg::BIT_LAST;
            FRAME_SYNC_N <= 1'b1;
            SHIFT_CLK    <= 1'b0;
            SER_DOUT     <= 1'b0;
            tx_r         <= '0;
        end
        else
        begin
            SHIFT_CLK <= tick_m;
            if (frame_start)
            begin
                bit_r        <= fsrg_pkg::BIT_FIRST;
                FRAME_SYNC_N <= 1'b0;
                SER_DOUT     <= ADC_WORD[fsrg_pkg::WORD_W-1];
                tx_r         <= {ADC_WORD[fsrg_pkg::WORD_W-2:0], 1'b0};
            end
            else if (tick_m)
            begin
                bit_r        <= bit_r + 4'h1;
                FRAME_SYNC_N <= 1'b1;
                SER_DOUT     <= tx_r[fsrg_pkg::WORD_W-1];
                tx_r         <= {tx_r[fsrg_pkg::WORD_W-2:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Receive shifter toward the DAC path
    // ------------------------------------------------------------
    logic [fsrg_pkg::WORD_W-1:0] rx_r;

    // No word exists before the first full frame, hence first_r
    always_ff @(posedge CLOCK)
    begin
        if (RST || restart)
        begin
            rx_r      <= '0;
            first_r   <= 1'b1;
            DAC_WORD  <= '0;
            DAC_VALID <= 1'b0;
        end
        else
        begin
            DAC_VALID <= frame_start && !first_r;
            if (tick_m)
            begin
                rx_r <= {rx_r[fsrg_pkg::WORD_W-2:0], din_s_r};
            end
            if (frame_start)
            begin
                first_r <= 1'b0;
            end
            if (frame_start && !first_r)
            begin
                DAC_WORD <= {rx_r[fsrg_pkg::WORD_W-2:0], din_s_r};
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [31:0] period_a;
    logic [31:0] cyc_a;
    logic [4:0]  ticks_a;

    assign period_a = 32'(fsrg_pkg::FRAME_BITS) * 32'(cfg_r.m) * 32'(cfg_r.n) * 32'(cfg_r.p);

    // Cycles and shift ticks since the last frame start
    always_ff @(posedge CLOCK)
    begin
        if (RST || restart || frame_start)
        begin
            cyc_a   <= 32'h00000001;
            ticks_a <= tick_m ? 5'h01 : 5'h00;
        end
        else
        begin
            cyc_a   <= cyc_a + 32'h00000001;
            ticks_a <= ticks_a + (tick_m ? 5'h01 : 5'h00);
        end
    end

    frame_period_a: assert property (@(posedge CLOCK) disable iff (RST)
        (frame_start && !first_r && !restart) |-> (cyc_a == period_a))
        else $error("frame period differs from 16*M*N*P");

    frame_bits_a: assert property (@(posedge CLOCK) disable iff (RST)
        (frame_start && !first_r && !restart) |-> (ticks_a == 5'h10))
        else $error("frame does not hold sixteen shift clocks");

    sync_fall_a: assert property (@(posedge CLOCK) disable iff (RST)
        $fell(FRAME_SYNC_N) |-> ($past(tick_m) && bit_r == fsrg_pkg::BIT_FIRST && SHIFT_CLK))
        else $error("frame sync fell outside a frame start");

    // Frame sync may only rise with a shift pulse, a restart or a reset
    sync_width_a: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(FRAME_SYNC_N) |-> (SHIFT_CLK || $past(restart) || $past(RST)))
        else $error("frame sync low not held for one shift clock");

    coarse_reset_a: assert property (@(posedge CLOCK)
        $past(RST) |-> (cfg_r.p == fsrg_pkg::P_COARSE) ##1 !FINE_MODE)
        else $error("reset did not select coarse mode");

    restart_chain_a: assert property (@(posedge CLOCK) disable iff (RST)
        restart |=> (FRAME_SYNC_N && bit_r == fsrg_pkg::BIT_LAST && !SHIFT_CLK))
        else $error("new setting did not restart the frame chain");

    dout_msb_a: assert property (@(posedge CLOCK) disable iff (RST)
        $fell(FRAME_SYNC_N) |-> (SER_DOUT == $past(ADC_WORD[fsrg_pkg::WORD_W-1])))
        else $error("serial output does not open with the ADC msb");

    dac_word_a: assert property (@(posedge CLOCK) disable iff (RST)
        DAC_VALID |-> (DAC_WORD[0] == $past(din_s_r) && !FRAME_SYNC_N))
        else $error("DAC word not taken at frame end");

endmodule

// ### design/fsrg_pkg.sv
package fsrg_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int WORD_W      = 16;
    localparam int M_W         = 8;
    localparam int N_W         = 5;
    localparam int P_W         = 4;
    localparam int BIT_W       = 4;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // Frame layout and defaults
    // ------------------------------------------------------------
    localparam int             FRAME_BITS = 16;
    localparam logic [BIT_W-1:0] BIT_FIRST = 4'h0;
    localparam logic [BIT_W-1:0] BIT_LAST  = 4'hF;
    localparam logic [P_W-1:0] P_COARSE   = 4'h8;
    localparam logic [M_W-1:0] M_DEFAULT  = 8'h01;
    localparam logic [N_W-1:0] N_DEFAULT  = 5'h01;

    // ------------------------------------------------------------
    // Divider configuration carried as one word
    // ------------------------------------------------------------
    typedef struct packed {
        logic [M_W-1:0] m;
        logic [N_W-1:0] n;
        logic [P_W-1:0] p;
    } fsrg_cfg_t;

endpackage

// ### design/fsrg_div.sv
`timescale 1ns/10ps

module fsrg_div #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         restart,
    input  wire logic         en,
    input  wire logic [W-1:0] div,
    output logic              tick
);

    logic [W-1:0] cnt_r;
    logic         last;

    // Terminal count; a divide value of zero wraps to two to the W
    assign last = (cnt_r == (div - {{(W-1){1'b0}}, 1'b1}));
    assign tick = en && last;

    // Stage counter, cleared so a new setting starts from a clean phase
    always_ff @(posedge clk)
    begin
        if (rst || restart)
        begin
            cnt_r <= '0;
        end
        else if (en)
        begin
            cnt_r <= last ? '0 : cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule

// ### dv/fsrg_host.sv
`timescale 1ns/10ps

module fsrg_host (
    input  wire logic        clk,
    input  wire logic        frame_n,
    input  wire logic        shift,
    input  wire logic        dout,
    input  wire logic [15:0] tx_word,
    output logic             din,
    output logic [15:0]      rx_word
);
    // ------------------------------------------------------------
    // Host serial port
    // ------------------------------------------------------------
    logic [3:0]  idx_r;
    logic [15:0] sh_r;
    logic [3:0]  idx;

    initial
    begin
        din = 1'b0;
        rx_word = 16'h0000;
        idx_r = 4'h0;
        sh_r = 16'h0000;
    end

    // Bit 0 is marked by frame sync low; din moves just after the pulse
    always @(posedge clk)
    begin
        if (shift === 1'b1)
        begin
            idx = (frame_n === 1'b0) ? 4'h0 : idx_r + 4'h1;
            din <= #1 tx_word[4'hF - idx];
            sh_r <= {sh_r[14:0], dout};
            if (idx == 4'hF)
            begin
                rx_word <= {sh_r[14:0], dout};
            end
            idx_r <= idx;
        end
    end
endmodule

// ### dv/fsrg_top_test.sv
`timescale 1ns/10ps

module fsrg_top_test;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                CLOCK;
    logic                RST;
    fsrg_pkg::fsrg_cfg_t CFG;
    logic                CFG_WR;
    logic [15:0]         ADC_WORD;
    logic                SER_DIN;
    logic                FRAME_SYNC_N;
    logic                SHIFT_CLK;
    logic                SER_DOUT;
    logic [15:0]         DAC_WORD;
    logic                DAC_VALID;
    logic                FINE_MODE;
    logic [15:0]         tx_word;
    logic [15:0]         rx_word;
    int                  bad_count;
    int                  checks;
    int                  n;

    fsrg_top fsrg_top_inst (
        .CLOCK(CLOCK), .RST(RST), .CFG(CFG), .CFG_WR(CFG_WR), .ADC_WORD(ADC_WORD),
        .SER_DIN(SER_DIN), .FRAME_SYNC_N(FRAME_SYNC_N), .SHIFT_CLK(SHIFT_CLK),
        .SER_DOUT(SER_DOUT), .DAC_WORD(DAC_WORD), .DAC_VALID(DAC_VALID),
        .FINE_MODE(FINE_MODE)
    );

    fsrg_host fsrg_host_inst (
        .clk(CLOCK), .frame_n(FRAME_SYNC_N), .shift(SHIFT_CLK), .dout(SER_DOUT),
        .tx_word(tx_word), .din(SER_DIN), .rx_word(rx_word)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    initial
    begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Counts edges up to the next frame sync fall; bounded against a hang
    task automatic wait_fall(output int cnt);
        logic prev;
        int   i;
        prev = FRAME_SYNC_N;
        cnt = 0;
        for (i = 0; i < 2000; i++)
        begin
            @(posedge CLOCK);
            #2;
            cnt++;
            if (prev === 1'b1 && FRAME_SYNC_N === 1'b0)
                return;
            prev = FRAME_SYNC_N;
        end
        bad_count++;
        test_done();
    endtask

    task automatic cfg_load(input logic [7:0] m, input logic [4:0] nn, input logic [3:0] p);
        @(posedge CLOCK);
        #1;
        CFG = '{m: m, n: nn, p: p};
        CFG_WR = 1'b1;
        @(posedge CLOCK);
        #1;
        CFG_WR = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset defaults to coarse, T=8; first frame then data both ways
    task automatic test_reset_data();
        check("fine_mode", FINE_MODE, 1'b0);
        wait_fall(n);
        check("first_fall", n, 8);
        wait_fall(n);
        check("coarse_period", n, 16 * 1 * 1 * 8);
        check("host_rx", rx_word, 16'hA5C3);
        check("dac_valid", DAC_VALID, 1'b1);
        check("dac_word", DAC_WORD, 16'h3C96);
    endtask

    // Mid-frame rewrite to fine mode: restart, no word, new rate
    task automatic test_restart();
        repeat (20) @(posedge CLOCK);
        #1;
        ADC_WORD = 16'h5A0F;
        tx_word = 16'hC381;
        cfg_load(8'h03, 5'h02, 4'h4);
        wait_fall(n);
        check("restart_fall", n, 3 * 2 * 4);
        check("abort_valid", DAC_VALID, 1'b0);
        check("fine_mode", FINE_MODE, 1'b1);
        wait_fall(n);
        check("fine_period", n, 16 * 3 * 2 * 4);
        check("host_rx", rx_word, 16'h5A0F);
        check("dac_word", DAC_WORD, 16'hC381);
    endtask

    // Coarse with larger M and N dividers
    task automatic test_coarse();
        cfg_load(8'h02, 5'h03, 4'h8);
        wait_fall(n);
        check("fine_mode", FINE_MODE, 1'b0);
        check("shift_at_fall", SHIFT_CLK, 1'b1);
        wait_fall(n);
        check("coarse_period", n, 16 * 2 * 3 * 8);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        RST = 1'b1;
        CFG = '{m: 8'h01, n: 5'h01, p: 4'h8};
        CFG_WR = 1'b0;
        ADC_WORD = 16'hA5C3;
        tx_word = 16'h3C96;
        bad_count = 0;
        checks = 0;
        repeat (8) @(posedge CLOCK);
        #1;
        RST = 1'b0;
        test_reset_data();
        test_restart();
        test_coarse();
        test_done();
    end
endmodule
